// File: core/gphy_pkg.sv
// Shared constants and types for the gigabit management register bank
package gphy_pkg;
    // Register addresses on the serial management interface
    localparam logic [4:0] REG_GIG_CTRL = 5'h09;
    localparam logic [4:0] REG_GIG_STAT = 5'h0A;
    localparam logic [4:0] REG_EXT_STAT = 5'h0F;
    // Gigabit control field positions
    localparam int CTRL_HD_BIT = 8;
    localparam int CTRL_FD_BIT = 9;
    localparam int CTRL_PORT_BIT = 10;
    localparam int CTRL_MVAL_BIT = 11;
    localparam int CTRL_MEN_BIT = 12;
    localparam int CTRL_TEST_LSB = 13;
    // Gigabit status field positions
    localparam int STAT_LP_HD_BIT = 10;
    localparam int STAT_LP_FD_BIT = 11;
    localparam int STAT_REM_RX_BIT = 12;
    localparam int STAT_LOC_RX_BIT = 13;
    localparam int STAT_MASTER_BIT = 14;
    localparam int STAT_FAULT_BIT = 15;
    // Reset values of the control bits: hardware reset, then software reset
    localparam logic HW_RST_ADV = 1'b1;
    localparam logic SW_RST_ADV = 1'b0;
    localparam logic HW_RST_PORT = 1'b1;
    localparam logic SW_RST_PORT = 1'b0;
    localparam logic RST_MANUAL = 1'b0;
    // Fixed extended ability word: 1000BASE-T half and full, no 1000BASE-X
    localparam logic [15:0] EXT_STAT_VALUE = 16'h3000;
    // Transmitter test mode codes
    localparam logic [2:0] TEST_NORMAL = 3'h0;
    localparam logic [2:0] TEST_WAVEFORM = 3'h1;
    localparam logic [2:0] TEST_JITTER_MASTER = 3'h2;
    localparam logic [2:0] TEST_JITTER_SLAVE = 3'h3;
    // Management frame layout
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [4:0] HDR_BITS = 5'h0D;
    localparam logic [4:0] TA_BITS = 5'h02;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [7:0] IDLE_CNT_MAX = 8'hFF;
    localparam int SEED_W = 11;
    typedef enum logic [2:0] {
        ST_PREAMBLE, ST_HEADER, ST_TURN_RD, ST_READ, ST_TURN_WR, ST_WRITE
    } mdio_state_t;
endpackage

// File: core/role_if.sv
// Signals between the register bank and the role resolver
`timescale 1ns/1ps
interface role_if;
    logic manual_en;
    logic manual_val;
    logic port_type;
    logic lp_manual_en;
    logic lp_manual_val;
    logic lp_port_type;
    logic [gphy_pkg::SEED_W-1:0] local_seed;
    logic [gphy_pkg::SEED_W-1:0] lp_seed;
    logic resolve;
    logic clear;
    logic master;
    logic fault_event;
    modport bank (output manual_en, manual_val, port_type, lp_manual_en, lp_manual_val,
        lp_port_type, local_seed, lp_seed, resolve, clear, input master, fault_event);
    modport resolver (input manual_en, manual_val, port_type, lp_manual_en, lp_manual_val,
        lp_port_type, local_seed, lp_seed, resolve, clear, output master, fault_event);
endinterface

// File: core/role_resolver.sv
// MASTER/SLAVE role resolution from local and partner configuration
`timescale 1ns/1ps
module role_resolver (
    input wire logic sys_clk,
    input wire logic reset_n,
    role_if.resolver rif
);
    import gphy_pkg::*;

    typedef struct packed {
        logic master;
        logic fault_event;
    } res_state_t;

    res_state_t q;
    res_state_t d;

    // Resolve on request; a fault leaves the port SLAVE and pulses the event
    always_comb begin
        d = q;
        d.fault_event = 1'b0;
        if (rif.clear) begin
            d = '0;
        end else if (rif.resolve) begin
            if (rif.manual_en && rif.lp_manual_en) begin
                if (rif.manual_val == rif.lp_manual_val) begin
                    d.fault_event = 1'b1;
                end else begin
                    d.master = rif.manual_val; // [R3] [R4]
                end
            end else if (rif.manual_en) begin
                d.master = rif.manual_val; // [R3] [R4]
            end else if (rif.lp_manual_en) begin
                d.master = ~rif.lp_manual_val;
            end else if (rif.port_type != rif.lp_port_type) begin
                d.master = rif.port_type; // [R16]
            end else if (rif.local_seed != rif.lp_seed) begin
                d.master = (rif.local_seed > rif.lp_seed);
            end else begin
                d.fault_event = 1'b1;
            end
            if (d.fault_event) begin
                d.master = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rif.master = q.master;
    assign rif.fault_event = q.fault_event;
endmodule

// File: core/gphy_mgmt_regs.sv
// Gigabit control and status registers behind the serial management interface
//
// What this block does
// [R1] Half-duplex advert bit drives advertisement; reset 1 by hardware, 0 by software.
// [R2] Full-duplex advert bit drives advertisement; reset 1 by hardware, 0 by software.
// [R3] Manual role value: 1 forces MASTER, 0 forces SLAVE; resets to 0.
// [R4] Manual value applies only while manual enable is 1; enable resets to 0.
// [R5] Three-bit test mode field in control bits 15:13, resets to normal.
// [R6] Test codes: 0 normal, 1 waveform, 2 jitter MASTER, 3 jitter SLAVE.
// [R7] Status bit shows partner advertised 1000BASE-T half duplex; resets 0.
// [R8] Status bit shows partner advertised 1000BASE-T full duplex; resets 0.
// [R9] Status bit shows remote receiver OK; resets 0.
// [R10] Status bit shows local receiver OK; resets 0.
// [R11] Status bit shows resolved role, 1 MASTER 0 SLAVE; resets 0.
// [R12] Role fault bit latches on fault, clears when read; resets 0.
// [R13] Extended status always reads 1 in 1000BASE-T half-duplex ability.
// [R14] Extended status always reads 1 in 1000BASE-T full-duplex ability.
// [R15] Extended status reads 0 in 1000BASE-X bits and low twelve bits.
// [R16] Port type bit prefers MASTER when 1; hardware reset 1, software 0.
// [R17] Eight-bit read-only idle error count in status register, resets to zero.
`timescale 1ns/1ps
module gphy_mgmt_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic soft_reset,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Partner abilities and receiver state
    input wire logic lp_adv_1000_hd,
    input wire logic lp_adv_1000_fd,
    input wire logic remote_rx_ok,
    input wire logic local_rx_ok,
    input wire logic idle_error,
    // Partner role setup, seeds and the resolve strobe
    input wire logic lp_manual_en,
    input wire logic lp_manual_val,
    input wire logic lp_port_type,
    input wire logic [gphy_pkg::SEED_W-1:0] local_seed,
    input wire logic [gphy_pkg::SEED_W-1:0] lp_seed,
    input wire logic role_resolve,
    // Control register fields and the resolved role
    output logic adv_1000_hd,
    output logic adv_1000_fd,
    output logic port_type_multi,
    output logic manual_role_en,
    output logic manual_role_val,
    output logic [2:0] test_mode,
    output logic role_master
);
    import gphy_pkg::*;

    typedef struct packed {
        // Pin synchronisers; the third clock flop finds the rising edge
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_s3;
        logic mdio_s1;
        logic mdio_s2;

        // Frame engine and the read or write data shift
        mdio_state_t state;
        logic [5:0] pre_cnt;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic [4:0] wr_addr;
        logic mdio_out;
        logic mdio_oe;

        // Control register fields
        logic adv_hd;
        logic adv_fd;
        logic port_type;
        logic man_en;
        logic man_val;
        logic [2:0] test_mode;

        // Status levels, latched fault and idle error count
        logic lp_hd;
        logic lp_fd;
        logic rem_ok;
        logic loc_ok;
        logic fault;
        logic [7:0] idle_cnt;
    } bank_state_t;

    bank_state_t q;
    bank_state_t d;
    role_if rif();
    logic mdc_rise;
    logic mdio_bit;
    logic [12:0] hdr;
    logic [15:0] wdata;

    // Pack the control word from the stored fields
    function automatic logic [15:0] ctrl_word(input bank_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[CTRL_HD_BIT] = s.adv_hd;
        w[CTRL_FD_BIT] = s.adv_fd;
        w[CTRL_PORT_BIT] = s.port_type;
        w[CTRL_MVAL_BIT] = s.man_val;
        w[CTRL_MEN_BIT] = s.man_en;
        w[CTRL_TEST_LSB+2:CTRL_TEST_LSB] = s.test_mode;
        return w;
    endfunction

    // Read data for an address; unmapped addresses read zero
    function automatic logic [15:0] read_word(input bank_state_t s, input logic [4:0] addr,
                                              input logic master);
        logic [15:0] w;
        w = 16'h0000;
        unique case (addr)
            REG_GIG_CTRL: w = ctrl_word(s);
            // Status word: count, partner abilities, receivers, role and fault
            REG_GIG_STAT: begin
                w[7:0] = s.idle_cnt; // [R17]
                w[STAT_LP_HD_BIT] = s.lp_hd; // [R7]
                w[STAT_LP_FD_BIT] = s.lp_fd; // [R8]
                w[STAT_REM_RX_BIT] = s.rem_ok; // [R9]
                w[STAT_LOC_RX_BIT] = s.loc_ok; // [R10]
                w[STAT_MASTER_BIT] = master; // [R11]
                w[STAT_FAULT_BIT] = s.fault; // [R12]
            end
            REG_EXT_STAT: w = EXT_STAT_VALUE; // [R13] [R14] [R15]
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // Edge of the synchronised management clock and the bit it samples
    assign mdc_rise = q.mdc_s2 & ~q.mdc_s3;
    assign mdio_bit = q.mdio_s2;

    // Header and write data views of the shift with the new bit appended
    assign hdr = {q.shift[11:0], mdio_bit};
    assign wdata = {q.shift[14:0], mdio_bit};

    // Role resolver hookup
    assign rif.manual_en = q.man_en;
    assign rif.manual_val = q.man_val;
    assign rif.port_type = q.port_type;

    // Partner configuration and the seeds that break a tie
    assign rif.lp_manual_en = lp_manual_en;
    assign rif.lp_manual_val = lp_manual_val;
    assign rif.lp_port_type = lp_port_type;
    assign rif.local_seed = local_seed;
    assign rif.lp_seed = lp_seed;

    // Resolve strobe; software reset sends the role back to SLAVE
    assign rif.resolve = role_resolve;
    assign rif.clear = soft_reset;

    role_resolver u_resolver (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .rif(rif.resolver)
    );

    // Next state: synchronisers, status capture, frame engine, soft reset
    always_comb begin
        logic clear_on_read;
        clear_on_read = 1'b0;
        d = q;
        d.mdc_s1 = mdc;
        d.mdc_s2 = q.mdc_s1;
        d.mdc_s3 = q.mdc_s2;
        d.mdio_s1 = mdio_in;
        d.mdio_s2 = q.mdio_s1;

        // Status levels follow their inputs one clock late
        d.lp_hd = lp_adv_1000_hd; // [R7]
        d.lp_fd = lp_adv_1000_fd; // [R8]
        d.rem_ok = remote_rx_ok; // [R9]
        d.loc_ok = local_rx_ok; // [R10]

        if (mdc_rise) begin
            unique case (q.state)
                // Count ones; a zero after a full preamble starts the header
                ST_PREAMBLE: begin
                    if (mdio_bit) begin
                        if (q.pre_cnt != PREAMBLE_BITS) begin
                            d.pre_cnt = q.pre_cnt + 6'h01;
                        end
                    end else begin
                        if (q.pre_cnt == PREAMBLE_BITS) begin
                            d.state = ST_HEADER;
                            d.bit_cnt = 5'h00;
                        end
                        d.pre_cnt = 6'h00;
                    end
                end

                // Shift in start, opcode, address and register; decide at the last bit
                ST_HEADER: begin
                    d.shift = wdata;
                    d.bit_cnt = q.bit_cnt + 5'h01;
                    if (q.bit_cnt == HDR_BITS - 5'h01) begin
                        d.state = ST_PREAMBLE;
                        d.bit_cnt = 5'h00;
                        // Answer only a valid start bit and our own address
                        if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
                            if (hdr[11:10] == OP_READ) begin
                                d.state = ST_TURN_RD;
                                d.shift = read_word(q, hdr[4:0], rif.master);
                                clear_on_read = (hdr[4:0] == REG_GIG_STAT);
                            end else if (hdr[11:10] == OP_WRITE) begin
                                d.state = ST_TURN_WR;
                                d.wr_addr = hdr[4:0];
                            end
                        end
                    end
                end

                // Drive the low turnaround bit
                ST_TURN_RD: begin
                    d.mdio_out = 1'b0;
                    d.mdio_oe = 1'b1;
                    d.state = ST_READ;
                end

                // Launch one data bit per clock rise, release after the last
                ST_READ: begin
                    if (q.bit_cnt == DATA_BITS) begin
                        d.mdio_out = 1'b0;
                        d.mdio_oe = 1'b0;
                        d.state = ST_PREAMBLE;
                        d.bit_cnt = 5'h00;
                    end else begin
                        d.mdio_out = q.shift[15];
                        d.shift = {q.shift[14:0], 1'b0};
                        d.bit_cnt = q.bit_cnt + 5'h01;
                    end
                end

                // Let the two turnaround bits pass
                ST_TURN_WR: begin
                    d.bit_cnt = q.bit_cnt + 5'h01;
                    if (q.bit_cnt == TA_BITS - 5'h01) begin
                        d.state = ST_WRITE;
                        d.bit_cnt = 5'h00;
                    end
                end

                // Shift in data; commit to the control word at the last bit
                ST_WRITE: begin
                    d.shift = wdata;
                    d.bit_cnt = q.bit_cnt + 5'h01;
                    if (q.bit_cnt == DATA_BITS - 5'h01) begin
                        d.state = ST_PREAMBLE;
                        d.bit_cnt = 5'h00;
                        // Only the control register takes writes; the rest are read only
                        if (q.wr_addr == REG_GIG_CTRL) begin
                            d.adv_hd = wdata[CTRL_HD_BIT]; // [R1]
                            d.adv_fd = wdata[CTRL_FD_BIT]; // [R2]
                            d.port_type = wdata[CTRL_PORT_BIT]; // [R16]
                            d.man_val = wdata[CTRL_MVAL_BIT]; // [R3]
                            d.man_en = wdata[CTRL_MEN_BIT]; // [R4]
                            d.test_mode = wdata[CTRL_TEST_LSB+2:CTRL_TEST_LSB]; // [R5] [R6]
                        end
                    end
                end

                // Unused codes fall back to the preamble hunt
                default: d.state = ST_PREAMBLE;
            endcase
        end

        // Read of the status word clears fault and count; a new event still wins
        if (clear_on_read) begin
            d.fault = 1'b0; // [R12]
            d.idle_cnt = 8'h00;
        end

        // A role fault from the resolver latches until the status word is read
        if (rif.fault_event) begin
            d.fault = 1'b1; // [R12]
        end

        // Idle errors count up and stop at the top; after a clear the count restarts at zero
        if (idle_error && d.idle_cnt != IDLE_CNT_MAX) begin
            d.idle_cnt = d.idle_cnt + 8'h01; // [R17]
        end

        // Software reset loads its own defaults; the frame engine is left alone
        if (soft_reset) begin
            d.adv_hd = SW_RST_ADV; // [R1] [R2]
            d.adv_fd = SW_RST_ADV;
            d.port_type = SW_RST_PORT; // [R16]
            d.man_en = RST_MANUAL; // [R4]
            d.man_val = RST_MANUAL; // [R3]
            d.test_mode = TEST_NORMAL; // [R5]
            // Status levels and latched events start again from zero
            d.lp_hd = 1'b0;
            d.lp_fd = 1'b0;
            d.rem_ok = 1'b0;
            d.loc_ok = 1'b0;
            d.fault = 1'b0;
            d.idle_cnt = 8'h00;
        end
    end

    // State register; hardware reset loads the hardware defaults
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q <= '0;
            // Clock flops start high so a high pin after reset never reads as a rise
            q.mdc_s1 <= 1'b1;
            q.mdc_s2 <= 1'b1;
            q.mdc_s3 <= 1'b1;
            q.adv_hd <= HW_RST_ADV; // [R1]
            q.adv_fd <= HW_RST_ADV; // [R2]
            q.port_type <= HW_RST_PORT; // [R16]
            q.man_en <= RST_MANUAL; // [R4]
            q.man_val <= RST_MANUAL; // [R3]
            q.test_mode <= TEST_NORMAL; // [R5]
        end else begin
            q <= d;
        end
    end

    // Management line driver, enabled only while a read answer is on the line
    assign mdio_out = q.mdio_out;
    assign mdio_oe = q.mdio_oe;

    // Control fields straight from the state register
    assign adv_1000_hd = q.adv_hd; // [R1]
    assign adv_1000_fd = q.adv_fd; // [R2]
    assign port_type_multi = q.port_type;
    assign manual_role_en = q.man_en;
    assign manual_role_val = q.man_val;
    assign test_mode = q.test_mode; // [R6]

    // Resolved role, registered inside the resolver
    assign role_master = rif.master; // [R11]
endmodule

// File: tb/gphy_mgmt_regs_sva.sv
// Concurrent checks on the gigabit management register ports
`timescale 1ns/1ps
module gphy_mgmt_regs_sva (
    input logic sys_clk,
    input logic reset_n,
    input logic soft_reset,
    input logic mdc,
    input logic mdio_oe,
    input logic role_resolve,
    input logic lp_manual_en,
    input logic lp_manual_val,
    input logic lp_port_type,
    input logic adv_1000_hd,
    input logic adv_1000_fd,
    input logic port_type_multi,
    input logic manual_role_en,
    input logic manual_role_val,
    input logic [2:0] test_mode,
    input logic role_master
);
    import gphy_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Reset loads, role resolution and hold relations
    a_hw_defaults: assert property (
        disable iff (1'b0) !reset_n |=> adv_1000_hd && adv_1000_fd && port_type_multi
        && !manual_role_en && !mdio_oe && test_mode == TEST_NORMAL)
        else $error("hardware reset values wrong");
    a_soft_defaults: assert property (
        soft_reset |=> !adv_1000_hd && !adv_1000_fd && !port_type_multi && !manual_role_en
        && !manual_role_val && test_mode == TEST_NORMAL && !role_master)
        else $error("software reset values wrong");
    a_ctrl_steady: assert property (
        (!mdc && !soft_reset) [*8] |-> $stable({adv_1000_hd, adv_1000_fd, test_mode}))
        else $error("control changed without a frame");
    a_manual_local: assert property (
        role_resolve && !soft_reset && manual_role_en
        && !(lp_manual_en && lp_manual_val == manual_role_val)
        |=> role_master == $past(manual_role_val))
        else $error("manual role not applied");
    a_partner_manual: assert property (
        role_resolve && !soft_reset && !manual_role_en && lp_manual_en
        |=> role_master == !$past(lp_manual_val))
        else $error("role not opposite to partner");
    a_port_pref: assert property (
        role_resolve && !soft_reset && !manual_role_en && !lp_manual_en
        && port_type_multi != lp_port_type |=> role_master == $past(port_type_multi))
        else $error("port type preference ignored");
    a_fault_slave: assert property (
        role_resolve && !soft_reset && manual_role_en && lp_manual_en
        && manual_role_val == lp_manual_val |=> !role_master)
        else $error("role fault not slave");
    a_role_hold: assert property (
        !role_resolve && !soft_reset |=> $stable(role_master))
        else $error("role changed without resolve");
endmodule
bind gphy_mgmt_regs gphy_mgmt_regs_sva chk (.sys_clk, .reset_n, .soft_reset, .mdc, .mdio_oe,
    .role_resolve, .lp_manual_en, .lp_manual_val, .lp_port_type, .adv_1000_hd, .adv_1000_fd,
    .port_type_multi, .manual_role_en, .manual_role_val, .test_mode, .role_master);

// File: tb/link_partner_model.sv
// Link partner model: abilities, receiver state and role configuration
`timescale 1ns/1ps
module link_partner_model (
    input wire logic sys_clk,
    output logic lp_adv_1000_hd,
    output logic lp_adv_1000_fd,
    output logic remote_rx_ok,
    output logic lp_manual_en,
    output logic lp_manual_val,
    output logic lp_port_type,
    output logic [gphy_pkg::SEED_W-1:0] lp_seed
);
    import gphy_pkg::*;
    // New partner state lands on a falling edge
    task automatic set_cfg(input logic [5:0] c, input logic [SEED_W-1:0] s);
        @(negedge sys_clk);
        {lp_adv_1000_hd, lp_adv_1000_fd, remote_rx_ok, lp_manual_en, lp_manual_val} = c[5:1];
        lp_port_type = c[0];
        lp_seed = s;
    endtask
    initial begin
        {lp_adv_1000_hd, lp_adv_1000_fd, remote_rx_ok, lp_manual_en, lp_manual_val} = 5'h00;
        lp_port_type = 1'b0;
        lp_seed = 11'h000;
    end
endmodule

// File: tb/gphy_mgmt_regs_test.sv
// Self-checking bench for the gigabit management register bank
`timescale 1ns/1ps
module gphy_mgmt_regs_test;
    import gphy_pkg::*;
    localparam logic [4:0] PHY_A = 5'h01;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic soft_reset = 1'b0;
    logic mdc = 1'b1;
    logic drv = 1'b1;
    logic local_rx_ok = 1'b0;
    logic idle_error = 1'b0;
    logic role_resolve = 1'b0;
    logic [SEED_W-1:0] local_seed = 11'h000;
    logic [SEED_W-1:0] lp_seed;
    logic lp_adv_1000_hd, lp_adv_1000_fd, remote_rx_ok;
    logic lp_manual_en, lp_manual_val, lp_port_type;
    logic adv_1000_hd, adv_1000_fd, port_type_multi, manual_role_en, manual_role_val;
    logic mdio_out, mdio_oe, role_master;
    logic [2:0] test_mode;
    logic [2:0] n;
    logic [5:0] p;
    logic [1:0] fm;
    logic [31:0] rng = 32'h0000449A;
    logic [15:0] rd, w, e;
    int bad_count = 0;
    int tests_run = 0;
    // Line level with pull-up when the block is not driving
    wire mdio_line = mdio_oe ? mdio_out : drv;
    wire [15:0] pins = {test_mode, manual_role_en, manual_role_val, port_type_multi,
        adv_1000_fd, adv_1000_hd, 8'h00};
    gphy_mgmt_regs #(.PHY_ADDR(PHY_A)) uut (.sys_clk, .reset_n, .soft_reset, .mdc,
        .mdio_in(mdio_line), .mdio_out, .mdio_oe, .lp_adv_1000_hd, .lp_adv_1000_fd,
        .remote_rx_ok, .local_rx_ok, .idle_error, .lp_manual_en, .lp_manual_val,
        .lp_port_type, .local_seed, .lp_seed, .role_resolve, .adv_1000_hd, .adv_1000_fd,
        .port_type_multi, .manual_role_en, .manual_role_val, .test_mode, .role_master);
    link_partner_model lp (.sys_clk, .lp_adv_1000_hd, .lp_adv_1000_fd, .remote_rx_ok,
        .lp_manual_en, .lp_manual_val, .lp_port_type, .lp_seed);
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Expected {fault, master}; c is the control word, p the partner state
    function automatic logic [1:0] role_ref(input logic [15:0] c, input logic [5:0] p,
        input logic [SEED_W-1:0] ls, input logic [SEED_W-1:0] ps);
        if (c[12] && p[2]) return (c[11] == p[1]) ? 2'b10 : {1'b0, c[11]};
        if (c[12]) return {1'b0, c[11]};
        if (p[2]) return {1'b0, !p[1]};
        if (c[10] != p[0]) return {1'b0, c[10]};
        if (ls != ps) return {1'b0, ls > ps};
        return 2'b10;
    endfunction
    task automatic check(input string what, input logic [15:0] ex, input logic [15:0] got);
        tests_run++;
        if (got !== ex) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One management bit: low phase drives, line sampled just before the rise
    task automatic mbit(input logic v, output logic s);
        @(negedge sys_clk);
        mdc = 1'b0;
        drv = v;
        repeat (4) @(negedge sys_clk);
        s = mdio_line;
        mdc = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    // Whole frame, read data lands in rd, one idle bit at the end
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
        input logic [15:0] wd);
        logic s;
        logic [64:0] b;
        b = {32'hFFFFFFFF, 2'b01, op, phy, ra, (op == OP_WRITE) ? {2'b10, wd} : 18'h3FFFF, 1'b1};
        for (int i = 64; i >= 0; i--) begin
            mbit(b[i], s);
            if (i >= 1 && i <= 16) rd[i-1] = s;
        end
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("pins hw", 16'h0700, pins);
        frame(OP_READ, PHY_A, REG_GIG_CTRL, 16'h0000);
        check("ctrl hw", 16'h0700, rd);
        frame(OP_WRITE, PHY_A, REG_EXT_STAT, 16'hFFFF);
        frame(OP_READ, PHY_A, REG_EXT_STAT, 16'h0000);
        check("ext", 16'h3000, rd);
        // Every test code with random control bits; a foreign address is ignored
        for (int c = 0; c < 8; c++) begin
            rng = xs(rng);
            w = {c[2:0], rng[12:0]};
            frame(OP_WRITE, PHY_A, REG_GIG_CTRL, w);
            frame(OP_WRITE, PHY_A ^ 5'h01, REG_GIG_CTRL, ~w);
            frame(OP_READ, PHY_A, REG_GIG_CTRL, 16'h0000);
            check("ctrl", w & 16'hFF00, rd);
            check("pins", w & 16'hFF00, pins);
        end
        // Partner state, idle errors and role result in the status word
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            w = {3'h0, rng[12:0]};
            p = rng[18:13];
            if (k == 0) begin
                w[12:11] = 2'b11;
                p[2:1] = 2'b11;
            end
            frame(OP_WRITE, PHY_A, REG_GIG_CTRL, w);
            // Park the management clock low so the control hold check sees a quiet stretch
            mdc = 1'b0;
            lp.set_cfg(p, rng[29:19]);
            rng = xs(rng);
            local_seed = rng[10:0];
            local_rx_ok = rng[11];
            n = rng[14:12];
            repeat (n) begin
                @(negedge sys_clk) idle_error = 1'b1;
                @(negedge sys_clk) idle_error = 1'b0;
            end
            @(negedge sys_clk) role_resolve = 1'b1;
            @(negedge sys_clk) role_resolve = 1'b0;
            fm = role_ref(w, p, local_seed, lp_seed);
            e = {fm, local_rx_ok, p[3], p[4], p[5], 2'b00, 5'h00, n};
            frame(OP_READ, PHY_A, REG_GIG_STAT, 16'h0000);
            check("status", e, rd);
            frame(OP_READ, PHY_A, REG_GIG_STAT, 16'h0000);
            check("status again", {1'b0, e[14:8], 8'h00}, rd);
        end
        @(negedge sys_clk) soft_reset = 1'b1;
        @(negedge sys_clk) soft_reset = 1'b0;
        check("pins soft", 16'h0000, pins);
        frame(OP_READ, PHY_A, REG_GIG_CTRL, 16'h0000);
        check("ctrl soft", 16'h0000, rd);
        conclude();
    end
    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
endmodule
